// *** hdl/i2c_slave_defs.svh ***
// constants for the i2c slave address and receive block
`ifndef I2C_SLAVE_DEFS_SVH
`define I2C_SLAVE_DEFS_SVH

// link event codes passed from the link domain
`define I2C_EV_NONE 3'h0
`define I2C_EV_START 3'h1
`define I2C_EV_STOP 3'h2
`define I2C_EV_RISE 3'h3
`define I2C_EV_FALL 3'h4

// byte framing
`define I2C_BYTE_BITS 4'h8
`define I2C_BIT_RST 4'h0

// 10-bit high address pattern and its compare mask, and the 7-bit compare mask
`define I2C_TEN_HI_TAG 5'h1e
`define I2C_TEN_HI_MASK 5'h1f
`define I2C_SEVEN_MASK 8'hfe

// reset values
`define I2C_ADDR_RST 8'h00
`define I2C_BUF_RST 8'h00
`define I2C_CKR_RST 1'b1

`endif

// *** hdl/i2c_slave_pkg.sv ***
// types for the i2c slave address and receive block
package i2c_slave_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_LOW = 3'b010,
    ST_DATA = 3'b011,
    ST_READ = 3'b100
  } slave_state_t;

  typedef enum logic [1:0] {
    MODE_7BIT = 2'b00,
    MODE_10BIT = 2'b01,
    MODE_7BIT_SS = 2'b10,
    MODE_10BIT_SS = 2'b11
  } port_mode_t;

endpackage

// *** hdl/i2c_slave_address_receive.sv ***
// i2c slave: condition detect, address match, reception and acknowledge
`include "i2c_slave_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module i2c_slave_address_receive #(
  parameter int SYNC_STAGES = 2
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // link pins, open drain
  input wire logic link_clk_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // configuration levels
  input wire i2c_slave_pkg::port_mode_t port_mode_select_i,
  input wire logic start_irq_enable_i,
  input wire logic stop_irq_enable_i,
  input wire logic address_hold_enable_i,
  input wire logic data_hold_enable_i,
  input wire logic ack_value_select_i,
  input wire logic stretch_enable_i,
  input wire logic buffer_overwrite_enable_i,
  input wire logic [7:0] address_mask_reg_i,
  // software strobes
  input wire logic [7:0] slave_address_wdata_i,
  input wire logic slave_address_write_i,
  input wire logic clock_release_set_i,
  input wire logic irq_clear_i,
  input wire logic buffer_read_i,
  input wire logic overflow_clear_i,
  // status
  output logic [7:0] receive_buffer_o,
  output logic buffer_full_flag_o,
  output logic receive_overflow_flag_o,
  output logic serial_irq_flag_o,
  output logic ack_result_status_o,
  output logic ack_time_status_o,
  output logic upper_address_pending_o,
  output logic clock_release_bit_o,
  output logic read_write_status_o,
  output logic prior_match_o,
  output logic start_seen_o,
  output logic stop_seen_o
);

  if (SYNC_STAGES < 2) begin : g_chk
    $error("SYNC_STAGES must be at least 2");
  end

  function automatic logic masked_eq(input logic [7:0] a, input logic [7:0] b,
                                     input logic [7:0] m);
    return ((a ^ b) & m) == 8'h00;
  endfunction

  // ---------------- link domain ----------------
  logic [1:0] lrst_q;
  logic [SYNC_STAGES-1:0] scl_sync_q;
  logic [SYNC_STAGES-1:0] sda_sync_q;
  logic scl_s, sda_s, scl_p_q, sda_p_q, low_seen_q;
  logic l_start, l_stop, l_rise, l_fall;
  logic [2:0] ev_code_q;
  logic ev_tgl_q, ev_sda_q;

  always_ff @(posedge link_clk_i) begin
    lrst_q <= {lrst_q[0], reset_i};
  end

  always_ff @(posedge link_clk_i) begin
    if (lrst_q[1]) begin
      scl_sync_q <= '1;
      sda_sync_q <= '1;
    end else begin
      scl_sync_q <= {scl_sync_q[SYNC_STAGES-2:0], scl_i};
      sda_sync_q <= {sda_sync_q[SYNC_STAGES-2:0], sda_i};
    end
  end

  assign scl_s = scl_sync_q[SYNC_STAGES-1];
  assign sda_s = sda_sync_q[SYNC_STAGES-1];
  assign l_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign l_stop = scl_s & scl_p_q & ~sda_p_q & sda_s & low_seen_q;
  assign l_rise = scl_s & ~scl_p_q;
  assign l_fall = ~scl_s & scl_p_q;

  always_ff @(posedge link_clk_i) begin
    if (lrst_q[1]) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      low_seen_q <= 1'b0;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      if (!scl_s) begin
        low_seen_q <= 1'b1;
      end else if (l_start) begin
        low_seen_q <= 1'b0;
      end
    end
  end

  // events cross by toggle; code and data stay put until the next event,
  // which the bus timing keeps far longer than the crossing latency
  always_ff @(posedge link_clk_i) begin
    if (lrst_q[1]) begin
      ev_tgl_q <= 1'b0;
      ev_code_q <= `I2C_EV_NONE;
      ev_sda_q <= 1'b1;
    end else if (l_start | l_stop | l_rise | l_fall) begin
      ev_tgl_q <= ~ev_tgl_q;
      ev_sda_q <= sda_s;
      if (l_start) begin
        ev_code_q <= `I2C_EV_START;
      end else if (l_stop) begin
        ev_code_q <= `I2C_EV_STOP;
      end else if (l_rise) begin
        ev_code_q <= `I2C_EV_RISE;
      end else begin
        ev_code_q <= `I2C_EV_FALL;
      end
    end
  end

  // ---------------- reference domain ----------------
  logic [2:0] ev_sync_q;
  logic ev, ev_start, ev_stop, ev_rise, ev_fall;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ev_sync_q <= 3'h0;
    end else begin
      ev_sync_q <= {ev_sync_q[1:0], ev_tgl_q};
    end
  end

  assign ev = ev_sync_q[2] ^ ev_sync_q[1];
  assign ev_start = ev && (ev_code_q == `I2C_EV_START);
  assign ev_stop = ev && (ev_code_q == `I2C_EV_STOP);
  assign ev_rise = ev && (ev_code_q == `I2C_EV_RISE);
  assign ev_fall = ev && (ev_code_q == `I2C_EV_FALL);

  i2c_slave_pkg::slave_state_t state_q, state_d;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q, adr_q, buf_q;
  logic in_ack_q, hit_q, ack_low_q, hold_q, prior_q, ua_q, ckr_q, rw_q;
  logic bf_q, ov_q, irq_q, ackres_q, ack_time_status_q, s_q, p_q, scl_oe_q, sda_oe_q;
  logic ten_bit, ss_mode, rw, hold_now, blocked, hi_hit, hit, byte_end;
  logic ack_end, acked, load, irq_set;

  assign ten_bit = (port_mode_select_i == i2c_slave_pkg::MODE_10BIT) ||
                   (port_mode_select_i == i2c_slave_pkg::MODE_10BIT_SS);
  assign ss_mode = (port_mode_select_i == i2c_slave_pkg::MODE_7BIT_SS) ||
                   (port_mode_select_i == i2c_slave_pkg::MODE_10BIT_SS);
  assign rw = shift_q[0];
  assign byte_end = ev_fall && (bit_cnt_q == `I2C_BYTE_BITS) && !in_ack_q;
  assign ack_end = ev_fall && in_ack_q;
  assign acked = sda_oe_q;
  assign hold_now = (state_q == i2c_slave_pkg::ST_DATA) ? data_hold_enable_i :
                    address_hold_enable_i;
  // overflow condition, overwrite enable lets a full buffer be replaced
  assign blocked = (bf_q & ~buffer_overwrite_enable_i) | ov_q;
  assign hi_hit = masked_eq(shift_q, {`I2C_TEN_HI_TAG, adr_q[2:1], 1'b0},
                            {`I2C_TEN_HI_MASK, address_mask_reg_i[2:1], 1'b0});

  always_comb begin
    hit = 1'b0;
    case (state_q)
      i2c_slave_pkg::ST_ADDR: begin
        if (!ten_bit) begin
          hit = masked_eq(shift_q, adr_q, address_mask_reg_i & `I2C_SEVEN_MASK);
        end else begin
          // read high byte only after a full write match
          hit = hi_hit & (~rw | prior_q);
        end
      end
      // low byte compared on every bit set in address_mask_reg_i, bit 0 included
      i2c_slave_pkg::ST_LOW: hit = masked_eq(shift_q, adr_q, address_mask_reg_i);
      i2c_slave_pkg::ST_DATA: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  assign load = byte_end & hit & ~blocked;

  always_comb begin
    state_d = state_q;
    if (ev_start) begin
      state_d = i2c_slave_pkg::ST_ADDR;
    end else if (ev_stop) begin
      state_d = i2c_slave_pkg::ST_IDLE;
    end else if (byte_end && !hit && (state_q == i2c_slave_pkg::ST_ADDR)) begin
      state_d = i2c_slave_pkg::ST_IDLE;
    end else if (ack_end) begin
      case (state_q)
        i2c_slave_pkg::ST_ADDR: begin
          if (!acked) begin
            state_d = i2c_slave_pkg::ST_IDLE;
          end else if (rw) begin
            state_d = i2c_slave_pkg::ST_READ;
          end else if (ten_bit) begin
            state_d = i2c_slave_pkg::ST_LOW;
          end else begin
            state_d = i2c_slave_pkg::ST_DATA;
          end
        end
        i2c_slave_pkg::ST_LOW: begin
          state_d = acked ? i2c_slave_pkg::ST_DATA : i2c_slave_pkg::ST_IDLE;
        end
        default: state_d = state_q;
      endcase
    end
  end

  // restart and start both reset the framing
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_q <= i2c_slave_pkg::ST_IDLE;
      bit_cnt_q <= `I2C_BIT_RST;
      in_ack_q <= 1'b0;
      shift_q <= `I2C_BUF_RST;
    end else begin
      state_q <= state_d;
      if (ev_start || ev_stop || ack_end) begin
        bit_cnt_q <= `I2C_BIT_RST;
        in_ack_q <= 1'b0;
      end else if (byte_end) begin
        in_ack_q <= 1'b1;
      end else if (ev_rise && (bit_cnt_q != `I2C_BYTE_BITS) &&
                   (state_q != i2c_slave_pkg::ST_IDLE)) begin
        shift_q <= {shift_q[6:0], ev_sda_q};
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
    end
  end

  // acknowledge result latched on ninth rising edge
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ackres_q <= 1'b0;
    end else if (ev_rise && in_ack_q) begin
      ackres_q <= ev_sda_q;
    end
  end

  // acknowledge decision taken after the eighth falling edge
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      hit_q <= 1'b0;
      ack_low_q <= 1'b0;
      hold_q <= 1'b0;
    end else if (ev_start || ev_stop) begin
      hit_q <= 1'b0;
    end else if (byte_end) begin
      hit_q <= hit;
      // automatic ack unless full without overwrite enable, or overflowed
      ack_low_q <= hit & ~blocked;
      hold_q <= hold_now;
    end
  end

  // software ack value under hold, receiver pulls sda low
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sda_oe_q <= 1'b0;
    end else begin
      sda_oe_q <= in_ack_q & ~ack_end & hit_q &
                  (hold_q ? ~ack_value_select_i : ack_low_q);
    end
  end

  // buffer load and full flag, load wins over read
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      buf_q <= `I2C_BUF_RST;
      bf_q <= 1'b0;
      ov_q <= 1'b0;
      rw_q <= 1'b0;
    end else begin
      if (load) begin
        buf_q <= shift_q;
        bf_q <= 1'b1;
      end else if (buffer_read_i) begin
        bf_q <= 1'b0;
      end
      if (byte_end && hit && bf_q && !buffer_overwrite_enable_i) begin
        ov_q <= 1'b1;
      end else if (overflow_clear_i) begin
        ov_q <= 1'b0;
      end
      if (byte_end && hit && (state_q == i2c_slave_pkg::ST_ADDR)) begin
        rw_q <= rw;
      end
    end
  end

  // prior match tracking for 10-bit reads
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || ev_stop) begin
      prior_q <= 1'b0;
    end else if (ack_end && acked && (state_q == i2c_slave_pkg::ST_LOW)) begin
      prior_q <= 1'b1;
    end else if (byte_end && ten_bit && (state_q == i2c_slave_pkg::ST_ADDR) &&
                 (!rw || !hi_hit)) begin
      prior_q <= 1'b0;
    end
  end

  // upper address pending, cleared by address rewrite
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ua_q <= 1'b0;
      adr_q <= `I2C_ADDR_RST;
    end else begin
      if (slave_address_write_i) begin
        adr_q <= slave_address_wdata_i;
      end
      if (ack_end && ((state_q == i2c_slave_pkg::ST_LOW) ||
          (acked && ten_bit && !rw && (state_q == i2c_slave_pkg::ST_ADDR)))) begin
        ua_q <= 1'b1;
      end else if (slave_address_write_i) begin
        ua_q <= 1'b0;
      end
    end
  end

  // clock release bit; hardware clear wins over software set
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ckr_q <= `I2C_CKR_RST;
    end else if ((byte_end && hit && hold_now) ||
                 (ack_end && (state_q == i2c_slave_pkg::ST_LOW)) ||
                 (ack_end && acked && (state_q == i2c_slave_pkg::ST_ADDR) &&
                  (rw || ten_bit)) ||
                 (ack_end && acked && stretch_enable_i)) begin
      ckr_q <= 1'b0;
    end else if (clock_release_set_i || (slave_address_write_i && ua_q)) begin
      ckr_q <= 1'b1;
    end
  end

  // scl is held low while the release bit is clear
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      scl_oe_q <= 1'b0;
    end else begin
      scl_oe_q <= ~ckr_q;
    end
  end

  // ack time, only meaningful under hold
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || ev_start || ev_stop || ack_end) begin
      ack_time_status_q <= 1'b0;
    end else if (byte_end && hit && hold_now) begin
      ack_time_status_q <= 1'b1;
    end
  end

  assign irq_set = ((ev_start && (ss_mode || start_irq_enable_i)) ||
                    (ev_stop && (ss_mode || stop_irq_enable_i)) ||
                    (byte_end && hit && hold_now) ||
                    (ack_end && (state_q == i2c_slave_pkg::ST_LOW)) ||
                    (ack_end && acked && (state_q != i2c_slave_pkg::ST_IDLE)));

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      irq_q <= 1'b0;
      s_q <= 1'b0;
      p_q <= 1'b0;
    end else begin
      if (irq_set) begin
        irq_q <= 1'b1;
      end else if (irq_clear_i) begin
        irq_q <= 1'b0;
      end
      if (ev_start) begin
        s_q <= 1'b1;
        p_q <= 1'b0;
      end else if (ev_stop) begin
        s_q <= 1'b0;
        p_q <= 1'b1;
      end
    end
  end

  // open drain: output value fixed low, only the enables move
  always_ff @(posedge ref_clk_i) begin
    scl_o <= 1'b0;
    sda_o <= 1'b0;
  end

  assign scl_oe_o = scl_oe_q;
  assign sda_oe_o = sda_oe_q;
  assign receive_buffer_o = buf_q;
  assign buffer_full_flag_o = bf_q;
  assign receive_overflow_flag_o = ov_q;
  assign serial_irq_flag_o = irq_q;
  assign ack_result_status_o = ackres_q;
  assign ack_time_status_o = ack_time_status_q;
  assign upper_address_pending_o = ua_q;
  assign clock_release_bit_o = ckr_q;
  assign read_write_status_o = rw_q;
  assign prior_match_o = prior_q;
  assign start_seen_o = s_q;
  assign stop_seen_o = p_q;

  // ---------------- checks ----------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_held;
    !ckr_q ##1 scl_oe_q;
  endsequence

  a_stop_idle: assert property (ev_stop |=> state_q == i2c_slave_pkg::ST_IDLE)
    else $error("stop did not idle the slave");
  a_restart_frame: assert property (ev_start |=> bit_cnt_q == 4'h0 && !in_ack_q
    && state_q == i2c_slave_pkg::ST_ADDR) else $error("restart did not reset framing");
  a_prior_clear: assert property (ev_stop |=> !prior_q)
    else $error("prior match survived stop");
  a_cond_irq: assert property ((ev_start || ev_stop) && ss_mode |=> irq_q)
    else $error("condition irq missing");
  a_ack_sample: assert property (ev_rise && in_ack_q |=> ackres_q == $past(ev_sda_q))
    else $error("ack result not stored");
  a_soft_ack: assert property (in_ack_q && hit_q && hold_q && !ack_end
    |=> sda_oe_q == !$past(ack_value_select_i)) else $error("software ack not driven");
  a_full_nack: assert property (byte_end && !hold_now && blocked
    |=> !ack_low_q ##1 !sda_oe_q) else $error("ack sent while overflowed");
  a_ack_time: assert property (ack_time_status_q |-> $past(hold_now) || $past(ack_time_status_q))
    else $error("ack time set without hold");
  a_ua_clear: assert property (slave_address_write_i && !ack_end |=> !ua_q)
    else $error("address write did not clear upper flag");
  a_stretch_hold: assert property (ack_end && acked && stretch_enable_i
    |=> s_held) else $error("scl not stretched after byte");
  a_irq_sticky: assert property (irq_q && !irq_clear_i |=> irq_q)
    else $error("irq flag dropped by itself");
  a_read_clear: assert property (buffer_read_i && !load |=> !bf_q)
    else $error("buffer read did not clear full flag");

endmodule

`default_nettype wire

// *** verification/i2c_master_model.sv ***
// behavioural i2c bus master driving open-drain scl and sda
`timescale 1ns/1ns
`default_nettype none

module i2c_master_model #(
  parameter int HALF_NS = 500
) (
  // wire levels
  input wire logic scl_i,
  input wire logic sda_i,
  // 1 releases the line to its pull-up
  output logic scl_rel_o,
  output logic sda_rel_o
);
  int n_stuck;

  initial begin
    scl_rel_o = 1'b1;
    sda_rel_o = 1'b1;
    n_stuck = 0;
  end

  // the slave may stretch, so a raised clock is waited for with a bound
  task automatic scl_up();
    int n;
    n = 0;
    scl_rel_o = 1'b1;
    while (scl_i !== 1'b1 && n < 4000) begin
      #20;
      n++;
    end
    if (n >= 4000) n_stuck++;
  endtask

  // start, also used as restart from a low clock
  task automatic start();
    sda_rel_o = 1'b1;
    #(HALF_NS / 2);
    scl_up();
    #(HALF_NS);
    sda_rel_o = 1'b0;
    #(HALF_NS);
    scl_rel_o = 1'b0;
    #(HALF_NS / 2);
  endtask

  task automatic stop();
    sda_rel_o = 1'b0;
    #(HALF_NS / 2);
    scl_up();
    #(HALF_NS);
    sda_rel_o = 1'b1;
    #(HALF_NS);
  endtask

  // sda dip while scl stays high
  task automatic dip();
    sda_rel_o = 1'b0;
    #(HALF_NS);
    sda_rel_o = 1'b1;
    #(HALF_NS);
  endtask

  // msb first, sda moved only while scl is low
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_rel_o = b[i];
      #(HALF_NS / 2);
      scl_up();
      #(HALF_NS);
      scl_rel_o = 1'b0;
      #(HALF_NS / 2);
    end
    // transmitter lets go of sda for the ninth pulse
    sda_rel_o = 1'b1;
    #(HALF_NS / 2);
    scl_up();
    ack = sda_i;
    #(HALF_NS);
    scl_rel_o = 1'b0;
    #(HALF_NS / 2);
  endtask
endmodule

`default_nettype wire

// *** verification/i2c_slave_address_receive_bench.sv ***
// self-checking bench for the i2c slave address and receive block
`timescale 1ns/1ns
`default_nettype none

`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", what, exp, got); end end

module i2c_slave_address_receive_bench;
  logic ref_clk_i, reset_i, link_clk_i;
  i2c_slave_pkg::port_mode_t mode;
  logic sie, pie, ahe, dhe, ack_sel, str_en, bo_en, wr, rel_set, irq_clr, buf_rd, ov_clr;
  logic [7:0] mask, wdata, rbuf;
  logic scl_od, scl_oe, sda_od, sda_oe, full, ovf, irq, ack_res, ack_tim, ua, ckr, rw;
  logic prior, st_seen, sp_seen, ack, hold_svc, snap_irq, snap_tim, snap_ckr;
  wire logic scl_rel, sda_rel, scl_w, sda_w;
  int checks = 0;
  int n_mismatch = 0;

  // open-drain wires with pull-ups
  assign scl_w = scl_rel & ~(scl_oe & ~scl_od);
  assign sda_w = sda_rel & ~(sda_oe & ~sda_od);

  always #10 ref_clk_i = ~ref_clk_i;
  always #3 link_clk_i = ~link_clk_i;

  i2c_master_model i_master (.scl_i(scl_w), .sda_i(sda_w), .scl_rel_o(scl_rel),
    .sda_rel_o(sda_rel));

  i2c_slave_address_receive i_dut (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .link_clk_i(link_clk_i),
    .scl_i(scl_w), .scl_o(scl_od), .scl_oe_o(scl_oe),
    .sda_i(sda_w), .sda_o(sda_od), .sda_oe_o(sda_oe),
    .port_mode_select_i(mode), .start_irq_enable_i(sie), .stop_irq_enable_i(pie),
    .address_hold_enable_i(ahe), .data_hold_enable_i(dhe), .ack_value_select_i(ack_sel),
    .stretch_enable_i(str_en), .buffer_overwrite_enable_i(bo_en), .address_mask_reg_i(mask),
    .slave_address_wdata_i(wdata), .slave_address_write_i(wr),
    .clock_release_set_i(rel_set), .irq_clear_i(irq_clr), .buffer_read_i(buf_rd),
    .overflow_clear_i(ov_clr), .receive_buffer_o(rbuf), .buffer_full_flag_o(full),
    .receive_overflow_flag_o(ovf), .serial_irq_flag_o(irq), .ack_result_status_o(ack_res),
    .ack_time_status_o(ack_tim), .upper_address_pending_o(ua), .clock_release_bit_o(ckr),
    .read_write_status_o(rw), .prior_match_o(prior), .start_seen_o(st_seen),
    .stop_seen_o(sp_seen));

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  task automatic strobe(input logic a, input logic r, input logic i, input logic b);
    @(posedge ref_clk_i);
    wr <= a;
    rel_set <= r;
    irq_clr <= i;
    buf_rd <= b;
    ov_clr <= b;
    @(posedge ref_clk_i);
    {wr, rel_set, irq_clr, buf_rd, ov_clr} <= 5'h00;
    tick(2);
  endtask

  task automatic write_addr(input logic [7:0] a);
    wdata <= a;
    strobe(1'b1, 1'b0, 1'b0, 1'b0);
  endtask

  // hold modes stall inside the byte, so software is served alongside the master
  task automatic xfer(input logic [7:0] b);
    bit done;
    bit served;
    int n;
    done = 0;
    served = 0;
    n = 0;
    fork
      begin
        i_master.send_byte(b, ack);
        done = 1;
      end
      while (!done && n < 1000) begin
        @(posedge ref_clk_i);
        n++;
        if (hold_svc && !served && scl_oe === 1'b1) begin
          served = 1;
          {snap_irq, snap_tim, snap_ckr} = {irq, ack_tim, ckr};
          strobe(1'b0, 1'b1, 1'b0, 1'b0);
        end
      end
    join
    if (n >= 1000) begin
      n_mismatch++;
      end_of_test();
    end
    tick(20);
  endtask

  task automatic s_irq_modes();
    logic [1:0] md [5] = '{2'h0, 2'h0, 2'h2, 2'h3, 2'h1};
    logic en [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    logic ex [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 5; i++) begin
      mode <= i2c_slave_pkg::port_mode_t'(md[i]);
      sie <= en[i];
      pie <= en[i];
      strobe(1'b0, 1'b0, 1'b1, 1'b0);
      i_master.start();
      tick(20);
      `CHK("start irq", ex[i], irq)
      `CHK("start seen", 1'b1, st_seen)
      strobe(1'b0, 1'b0, 1'b1, 1'b0);
      i_master.stop();
      tick(20);
      `CHK("stop irq", ex[i], irq)
      `CHK("stop seen", 1'b1, sp_seen)
    end
    // stop irq armed so that a false stop in the dip would show
    pie <= 1'b1;
    strobe(1'b0, 1'b0, 1'b1, 1'b0);
    i_master.dip();
    tick(20);
    `CHK("dip irq", 1'b0, irq)
    `CHK("dip stop", 1'b0, sp_seen)
    {sie, pie} <= 2'b00;
  endtask

  task automatic s_seven();
    mode <= i2c_slave_pkg::MODE_7BIT;
    write_addr(8'ha0);
    strobe(1'b0, 1'b0, 1'b1, 1'b1);
    i_master.start();
    xfer(8'ha0);
    `CHK("addr ack", 1'b0, ack)
    `CHK("ack status", 1'b0, ack_res)
    `CHK("buffer", 8'ha0, rbuf)
    `CHK("full", 1'b1, full)
    `CHK("direction", 1'b0, rw)
    `CHK("irq", 1'b1, irq)
    `CHK("ack time", 1'b0, ack_tim)
    xfer(8'h3c);
    `CHK("full ack", 1'b1, ack)
    `CHK("overflow", 1'b1, ovf)
    strobe(1'b0, 1'b0, 1'b1, 1'b1);
    `CHK("read clears full", 1'b0, full)
    str_en <= 1'b1;
    xfer(8'h5a);
    `CHK("data ack", 1'b0, ack)
    `CHK("data", 8'h5a, rbuf)
    `CHK("stretch", 2'b01, {ckr, scl_oe})
    strobe(1'b0, 1'b1, 1'b0, 1'b0);
    tick(10);
    `CHK("released", 2'b10, {ckr, scl_oe})
    // buffer left full: overwrite enable must still take the byte
    str_en <= 1'b0;
    bo_en <= 1'b1;
    xfer(8'h66);
    `CHK("overwrite ack", 1'b0, ack)
    `CHK("overwrite", 9'h066, {ovf, rbuf})
    bo_en <= 1'b0;
    i_master.stop();
    strobe(1'b0, 1'b0, 1'b1, 1'b1);
    i_master.start();
    xfer(8'ha2);
    `CHK("miss ack", 1'b1, ack)
    `CHK("miss irq", 1'b0, irq)
    i_master.stop();
    tick(1);
    // bit 1 masked off, so a3 only matches through the mask
    mask <= 8'hfd;
    i_master.start();
    xfer(8'ha3);
    `CHK("read ack", 1'b0, ack)
    `CHK("read dir", 1'b1, rw)
    `CHK("masked buffer", 8'ha3, rbuf)
    mask <= 8'hff;
    strobe(1'b0, 1'b1, 1'b1, 1'b1);
    i_master.stop();
    tick(1);
  endtask

  task automatic s_hold();
    {ahe, dhe, ack_sel, hold_svc} <= 4'hf;
    for (int k = 1; k >= 0; k--) begin
      ack_sel <= k[0];
      strobe(1'b0, 1'b0, 1'b1, 1'b1);
      i_master.start();
      xfer(8'ha0);
      `CHK("hold ack", k[0], ack)
      `CHK("hold irq", 1'b1, snap_irq)
      `CHK("hold time", 1'b1, snap_tim)
      `CHK("hold release", 1'b0, snap_ckr)
      `CHK("time after", 1'b0, ack_tim)
      i_master.stop();
      tick(1);
    end
    {ahe, dhe, ack_sel, hold_svc} <= 4'h0;
  endtask

  task automatic s_ten();
    mode <= i2c_slave_pkg::MODE_10BIT;
    write_addr(8'hf6);
    strobe(1'b0, 1'b0, 1'b1, 1'b1);
    i_master.start();
    xfer(8'hf6);
    `CHK("high ack", 1'b0, ack)
    `CHK("high held", 3'h7, {ua, scl_oe, irq})
    write_addr(8'h34);
    tick(10);
    `CHK("low wait", 2'b00, {ua, scl_oe})
    strobe(1'b0, 1'b0, 1'b1, 1'b1);
    xfer(8'h34);
    `CHK("low ack", 1'b0, ack)
    `CHK("low held", 4'hf, {ua, scl_oe, irq, prior})
    write_addr(8'hf6);
    strobe(1'b0, 1'b0, 1'b1, 1'b1);
    // restart after the full write match
    i_master.start();
    xfer(8'hf7);
    `CHK("read ack", 1'b0, ack)
    `CHK("read dir", 1'b1, rw)
    strobe(1'b0, 1'b1, 1'b1, 1'b1);
    i_master.stop();
    tick(20);
    `CHK("prior cleared", 1'b0, prior)
    i_master.start();
    xfer(8'hf7);
    `CHK("no prior ack", 1'b1, ack)
    strobe(1'b0, 1'b1, 1'b1, 1'b1);
    i_master.stop();
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    {ref_clk_i, link_clk_i, reset_i} = 3'b001;
    mode = i2c_slave_pkg::MODE_7BIT;
    {sie, pie, ahe, dhe, ack_sel, str_en, bo_en, hold_svc} = 8'h00;
    {wr, rel_set, irq_clr, buf_rd, ov_clr} = 5'h00;
    mask = 8'hff;
    wdata = 8'h00;
    tick(10);
    reset_i <= 1'b0;
    tick(3);
    `CHK("reset release bit", 1'b1, ckr)
    s_irq_modes();
    s_seven();
    s_hold();
    s_ten();
    `CHK("master stalls", 0, i_master.n_stuck)
    end_of_test();
  end

  // bounds the whole run
  initial begin
    #2000000;
    n_mismatch++;
    end_of_test();
  end
endmodule

`default_nettype wire
